// ===== hdl/scg_top.sv
/*
 * Sleep-mode clock gating controller with AHB-Lite registers.
 * Holds run, sleep and deep-sleep gate registers, picks one by power
 * mode, drives the unit clock enables, and faults bus accesses aimed
 * at units whose clock is off.
 * Assumes the power mode comes from pins of another domain, and unit
 * access requests come from the system decoder on this clock.
 */
`timescale 1ns/1ps
module scg_top
	import scg_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [1:0] I_POWER_MODE,
	input wire logic I_UNIT_REQ,
	input wire logic [3:0] I_UNIT_SEL,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [NUM_UNITS-1:0] O_UNIT_CLK_EN,
	output logic O_UNIT_FAULT,
	output logic O_IRQ
);
	// ****************************************
	// registers and wiring
	// ****************************************
	scg_gate_if g();
	scg_gate_sel u_sel (
		.g(g)
	);
	logic [1:0] mode_raw;
	logic [1:0] mode_last;
	// mode code seen by the gate selector and the status read
	logic [1:0] mode_sync;
	scg_sync #(.W(2)) u_sync (
		.i_clk(I_CLK),
		.i_nrst(I_NRST),
		.i_d(I_POWER_MODE),
		.o_q(mode_raw)
	);

	// ****************************************
	// power mode filter
	// ****************************************
	// a two-bit code may be caught half-changed; it is taken only once
	// two samples in a row agree, so no false mode reaches the gates
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			mode_last <= MODE_RUN;
		end else begin
			mode_last <= mode_raw;
		end
	end
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			mode_sync <= MODE_RUN;
		end else if (mode_raw == mode_last) begin
			mode_sync <= mode_raw;
		end
	end

	logic [31:0] run_gate_reg;
	logic [31:0] sleep_gate_reg;
	logic [31:0] deep_sleep_gate_reg;
	logic [31:0] run_mode_clock_config;
	logic [1:0] int_stat;
	logic [1:0] int_mask;
	logic [1:0] mode_prev;
	scg_bus_e bus_state;

	logic wr_pend;
	logic [11:0] wr_addr;
	logic [NUM_UNITS-1:0] unit_en;

	assign g.run_gate = run_gate_reg;
	assign g.sleep_gate = sleep_gate_reg;
	assign g.deep_gate = deep_sleep_gate_reg;
	assign g.auto_gating_select = run_mode_clock_config[AUTO_GATING_BIT];
	assign g.mode = mode_sync;

	// ****************************************
	// per-unit enables of the active gate vector
	// ****************************************
	logic port_a_clk_en;
	logic port_b_clk_en;
	logic port_c_clk_en;
	logic port_d_clk_en;
	logic port_e_clk_en;
	logic port_f_clk_en;
	logic port_g_clk_en;
	logic mac_unit_clk_en;
	logic phy_unit_clk_en;
	assign port_a_clk_en = g.active_gate[0];
	assign port_b_clk_en = g.active_gate[1];
	assign port_c_clk_en = g.active_gate[2];
	assign port_d_clk_en = g.active_gate[3];
	assign port_e_clk_en = g.active_gate[4];
	assign port_f_clk_en = g.active_gate[5];
	assign port_g_clk_en = g.active_gate[6];
	assign mac_unit_clk_en = g.active_gate[MAC_BIT];
	assign phy_unit_clk_en = g.active_gate[PHY_BIT];
	// folded to unit order: ports a..g, mac, phy
	assign unit_en = {phy_unit_clk_en, mac_unit_clk_en, port_g_clk_en,
		port_f_clk_en, port_e_clk_en, port_d_clk_en, port_c_clk_en,
		port_b_clk_en, port_a_clk_en};

	// ****************************************
	// ahb-lite address decode
	// ****************************************
	logic addr_phase;
	logic [11:0] a_ofs;
	logic a_mapped;
	assign addr_phase = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ ||
		HTRANS == 2'h3);
	assign a_ofs = {HADDR[11:2], 2'h0};
	always_comb begin
		unique case (a_ofs)
			RUN_CFG_OFS, RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS,
			INT_STAT_OFS, INT_MASK_OFS, MODE_STAT_OFS: a_mapped = 1'b1;
			default: a_mapped = 1'b0;
		endcase
	end

	// ****************************************
	// bus response: okay or two-cycle error
	// ****************************************
	// error: a wait cycle, then a ready cycle, HRESP high in both
	scg_bus_e next_bus_state;
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			SCG_IDLE: begin
				if (addr_phase && !a_mapped) begin
					next_bus_state = SCG_ERR1;
				end
			end
			SCG_ERR1: begin
				next_bus_state = SCG_ERR2;
			end
			SCG_ERR2: begin
				// a transfer queued behind an error is decoded here too
				if (addr_phase && !a_mapped) begin
					next_bus_state = SCG_ERR1;
				end else begin
					next_bus_state = SCG_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			bus_state <= SCG_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// outputs follow the next state so they leave a flip-flop
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_HREADYOUT <= 1'b1;
		end else begin
			O_HREADYOUT <= next_bus_state != SCG_ERR1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_HRESP <= 1'b0;
		end else begin
			O_HRESP <= next_bus_state != SCG_IDLE;
		end
	end

	// ****************************************
	// write capture and read data
	// ****************************************
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			wr_pend <= addr_phase && HWRITE && a_mapped;
			wr_addr <= a_ofs;
		end
	end

	// one write strobe per writable register (none for the mode status), valid in the data phase
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_cfg;
	logic wr_mask;
	logic wr_stat;
	assign wr_run = wr_pend && wr_addr == RUN_GATE_OFS;
	assign wr_sleep = wr_pend && wr_addr == SLEEP_GATE_OFS;
	assign wr_deep = wr_pend && wr_addr == DEEP_GATE_OFS;
	assign wr_cfg = wr_pend && wr_addr == RUN_CFG_OFS;
	assign wr_mask = wr_pend && wr_addr == INT_MASK_OFS;
	assign wr_stat = wr_pend && wr_addr == INT_STAT_OFS;

	// read word picked in the address phase, shown in the data phase
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h00000000;
		unique case (a_ofs)
			RUN_CFG_OFS: next_rdata = run_mode_clock_config;
			RUN_GATE_OFS: next_rdata = run_gate_reg;
			SLEEP_GATE_OFS: next_rdata = sleep_gate_reg;
			DEEP_GATE_OFS: next_rdata = deep_sleep_gate_reg;
			INT_STAT_OFS: next_rdata = {30'h00000000, int_stat};
			INT_MASK_OFS: next_rdata = {30'h00000000, int_mask};
			MODE_STAT_OFS: next_rdata = {30'h00000000, mode_sync};
			default: next_rdata = 32'h00000000;
		endcase
	end
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_HRDATA <= 32'h00000000;
		end else if (addr_phase && !HWRITE) begin
			O_HRDATA <= next_rdata;
		end
	end

	// ****************************************
	// gating registers
	// ****************************************
	// reserved bits are read-only zero; writes to them are dropped
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			run_gate_reg <= GATE_RESET;
		end else if (wr_run) begin
			run_gate_reg <= HWDATA & GATE_MASK;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			sleep_gate_reg <= GATE_RESET;
		end else if (wr_sleep) begin
			sleep_gate_reg <= HWDATA & GATE_MASK;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			deep_sleep_gate_reg <= GATE_RESET;
		end else if (wr_deep) begin
			deep_sleep_gate_reg <= HWDATA & GATE_MASK;
		end
	end

	// only the auto gating select bit of the run configuration is kept
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			run_mode_clock_config <= CFG_RESET;
		end else if (wr_cfg) begin
			run_mode_clock_config <= HWDATA & CFG_MASK;
		end
	end

	// one mask bit per event, same layout as the status
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			int_mask <= 2'h0;
		end else if (wr_mask) begin
			int_mask <= HWDATA[1:0] & INT_MASK_BITS;
		end
	end

	// ****************************************
	// unit clock enables
	// ****************************************
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_UNIT_CLK_EN <= '0;
		end else begin
			O_UNIT_CLK_EN <= unit_en;
		end
	end

	// ****************************************
	// fault on access to an unclocked unit
	// ****************************************
	logic unit_fault;
	logic sel_in_range;
	// indices past the last unit name nothing and never fault
	assign sel_in_range = I_UNIT_SEL < 4'(NUM_UNITS);
	assign unit_fault = I_UNIT_REQ && sel_in_range &&
		!O_UNIT_CLK_EN[I_UNIT_SEL];
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_UNIT_FAULT <= 1'b0;
		end else begin
			O_UNIT_FAULT <= unit_fault;
		end
	end

	// ****************************************
	// interrupts: sticky status, set wins over clear
	// ****************************************
	logic [1:0] ev;
	logic [1:0] clr;
	logic [1:0] next_int_stat;
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			mode_prev <= MODE_RUN;
		end else begin
			mode_prev <= mode_sync;
		end
	end
	always_comb begin
		ev = 2'h0;
		ev[EV_FAULT] = unit_fault;
		ev[EV_MODE] = mode_prev != mode_sync;
		clr = wr_stat ? HWDATA[1:0] : 2'h0;
		// an event in the cycle of its clear keeps its bit set
		next_int_stat = (int_stat & ~clr) | ev;
	end
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			int_stat <= 2'h0;
		end else begin
			int_stat <= next_int_stat;
		end
	end
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(next_int_stat & int_mask);
		end
	end
endmodule

// ===== shared/scg_pkg.sv
/*
 * Constants and types of the sleep-mode clock gating controller.
 * Assumes a single 200 MHz clock and an AHB-Lite register bus.
 */
package scg_pkg;
	localparam logic [11:0] RUN_CFG_OFS = 12'h060;
	localparam logic [11:0] RUN_GATE_OFS = 12'h108;
	localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
	localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
	localparam logic [11:0] INT_STAT_OFS = 12'h150;
	localparam logic [11:0] INT_MASK_OFS = 12'h154;
	localparam logic [11:0] MODE_STAT_OFS = 12'h158;
	localparam int PHY_BIT = 30;
	localparam int MAC_BIT = 28;
	localparam int NUM_UNITS = 9;
	localparam int AUTO_GATING_BIT = 27;
	localparam logic [31:0] GATE_MASK = 32'h5000007F;
	localparam logic [31:0] GATE_RESET = 32'h00000000;
	localparam logic [31:0] CFG_MASK = 32'h08000000;
	localparam logic [31:0] CFG_RESET = 32'h00000000;
	localparam logic [1:0] INT_MASK_BITS = 2'h3;
	localparam int EV_FAULT = 0;
	localparam int EV_MODE = 1;
	localparam logic [1:0] MODE_RUN = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_DEEP = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {SCG_IDLE, SCG_ERR1, SCG_ERR2} scg_bus_e;
endpackage

// ===== shared/scg_gate_if.sv
/*
 * Carries the gate registers, the auto gating select, the mode and the
 * selected gate vector between the controller and its gate selector.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface scg_gate_if;
	logic [31:0] run_gate;
	logic [31:0] sleep_gate;
	logic [31:0] deep_gate;
	logic auto_gating_select;
	logic [1:0] mode;
	logic [31:0] active_gate;
	modport ctrl (output run_gate, output sleep_gate, output deep_gate,
		output auto_gating_select, output mode, input active_gate);
	modport sel (input run_gate, input sleep_gate, input deep_gate,
		input auto_gating_select, input mode, output active_gate);
endinterface

// ===== hdl/scg_gate_sel.sv
/*
 * Chooses which gating register drives the unit clock enables.
 * Assumes the power mode code is stable for the current cycle.
 */
`timescale 1ns/1ps
module scg_gate_sel
	import scg_pkg::*;
(
	scg_gate_if.sel g
);
	always_comb begin
		g.active_gate = g.run_gate;
		if (g.auto_gating_select) begin
			if (g.mode == MODE_SLEEP) begin
				g.active_gate = g.sleep_gate;
			end else if (g.mode == MODE_DEEP) begin
				g.active_gate = g.deep_gate;
			end
		end
	end
endmodule

// ===== hdl/scg_sync.sv
/*
 * Two-flop synchroniser for a multi-bit level.
 * Assumes the bits change slowly relative to the clock.
 */
`timescale 1ns/1ps
module scg_sync #(
	parameter int W = 2
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta;
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta <= '0;
			o_q <= '0;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule

// ===== tb/scg_top_props.sv
/* Checker on the ports of the gating controller.
 * Assumes it is bound to scg_top. */
`timescale 1ns/1ps
module scg_top_props
	import scg_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [1:0] I_POWER_MODE,
	input wire logic I_UNIT_REQ,
	input wire logic [3:0] I_UNIT_SEL,
	input wire logic [31:0] O_HRDATA,
	input wire logic O_HREADYOUT,
	input wire logic O_HRESP,
	input wire logic [NUM_UNITS-1:0] O_UNIT_CLK_EN,
	input wire logic O_UNIT_FAULT
);
// ****
// helpers and properties
// ****
logic rd_q;
logic [1:0] pm_q;
logic [3:0] quiet;
always_ff @(posedge I_CLK) begin
	rd_q <= HSEL && HREADY && HTRANS[1] && !HWRITE
		&& HADDR[11:0] == SLEEP_GATE_OFS;
	pm_q <= I_POWER_MODE;
end
// cycles since the last bus transfer or mode change
always_ff @(posedge I_CLK) begin
	if (!I_NRST || (HSEL && HTRANS[1]) || I_POWER_MODE != pm_q)
		quiet <= 4'h0;
	else if (quiet != 4'hF)
		quiet <= quiet + 4'h1;
end
default clocking @(posedge I_CLK); endclocking
default disable iff (!I_NRST);
a_fault_when_off: assert property (
	I_UNIT_REQ && I_UNIT_SEL < 4'h9 && !O_UNIT_CLK_EN[I_UNIT_SEL]
	|=> O_UNIT_FAULT) else $error("no fault for gated unit");
a_quiet_when_on: assert property (
	I_UNIT_REQ && I_UNIT_SEL < 4'h9 && O_UNIT_CLK_EN[I_UNIT_SEL]
	|=> !O_UNIT_FAULT) else $error("fault for clocked unit");
a_fault_has_cause: assert property (
	O_UNIT_FAULT |-> $past(I_UNIT_REQ)) else $error("stray fault");
a_reset_all_off: assert property (
	$rose(I_NRST) |-> O_UNIT_CLK_EN == 9'h000)
	else $error("enable set after reset");
a_reserved_zero: assert property (
	rd_q && O_HREADYOUT |-> (O_HRDATA & ~GATE_MASK) == 32'h0)
	else $error("reserved bit reads one");
a_mapped_okay: assert property (
	rd_q && O_HREADYOUT |-> !O_HRESP) else $error("error on mapped read");
a_error_shape: assert property (
	$rose(O_HRESP) |-> !O_HREADYOUT ##1 O_HRESP && O_HREADYOUT)
	else $error("bad error response");
a_enable_steady: assert property (
	quiet > 4'h7 |-> $stable(O_UNIT_CLK_EN))
	else $error("enable moved without cause");
c_fault: cover property (O_UNIT_FAULT);
c_error: cover property ($rose(O_HRESP));
c_enable: cover property ($changed(O_UNIT_CLK_EN));
endmodule
bind scg_top scg_top_props scg_top_props_inst (.I_CLK, .I_NRST,
	.HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .I_POWER_MODE,
	.I_UNIT_REQ, .I_UNIT_SEL, .O_HRDATA, .O_HREADYOUT, .O_HRESP,
	.O_UNIT_CLK_EN, .O_UNIT_FAULT);

// ===== tb/scg_unit_model.sv
/* Gated unit side: raises one access request per command.
 * Assumes commands arrive just after a rising edge. */
`timescale 1ns/1ps
module scg_unit_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_sel,
	output logic o_req,
	output logic [3:0] o_sel
);
// ****
// request driver
// ****
initial begin
	o_req = 1'b0;
	o_sel = 4'h0;
end
// idle select toggles each cycle between the last index and its inverse
always @(posedge i_clk) begin
	o_req <= i_go;
	o_sel <= i_go ? i_sel : ~o_sel;
end
endmodule

// ===== tb/sleep_mode_clock_gating_test.sv
/* Self-checking bench of the gating controller.
 * Assumes scg_top, its checker and the unit model. */
`timescale 1ns/1ps
module sleep_mode_clock_gating_test
	import scg_pkg::*;
;
// ****
// bench
// ****
logic I_CLK = 1'b0, I_NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
logic go = 1'b0, ph = 1'b0, ph_rd = 1'b0, req_q = 1'b0;
logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, O_HRDATA;
logic [1:0] HTRANS = 2'h0, I_POWER_MODE = 2'h0;
logic [3:0] sel = 4'h0;
wire logic I_UNIT_REQ, O_HREADYOUT, O_HRESP, O_UNIT_FAULT, O_IRQ;
wire logic [3:0] I_UNIT_SEL;
wire logic [NUM_UNITS-1:0] O_UNIT_CLK_EN;
int errors = 0, total_checks = 0, seed = 8;
logic [31:0] exp_r[$], exp_d[$], exp_f[$];
always #2.5 I_CLK = ~I_CLK;
scg_top scg_top_inst (.I_CLK, .I_NRST, .HSEL, .HADDR, .HTRANS, .HWRITE,
	.HSIZE(3'h2), .HWDATA, .HREADY(O_HREADYOUT), .I_POWER_MODE,
	.I_UNIT_REQ, .I_UNIT_SEL, .O_HRDATA, .O_HREADYOUT, .O_HRESP,
	.O_UNIT_CLK_EN, .O_UNIT_FAULT, .O_IRQ);
scg_unit_model scg_unit_model_inst (.i_clk(I_CLK), .i_go(go),
	.i_sel(sel), .o_req(I_UNIT_REQ), .o_sel(I_UNIT_SEL));
task chk(input logic [31:0] seen, input logic [31:0] want);
	total_checks++;
	if (seen !== want) begin
		errors++;
		$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
	end
endtask
task conclude;
	$display("checks %0d errors %0d", total_checks, errors);
	if (errors == 0 && total_checks > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task waitc(input int n);
	repeat (n) @(posedge I_CLK);
endtask
task hrdy;
	int k;
	k = 0;
	do begin
		@(posedge I_CLK);
		k++;
	end while (O_HREADYOUT !== 1'b1 && k < 50);
	if (O_HREADYOUT !== 1'b1) begin
		errors++;
		conclude();
	end
endtask
task bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
	input logic [31:0] ed = 32'h0, input logic [31:0] er = 32'h0);
	exp_r.push_back(er);
	if (!wr)
		exp_d.push_back(ed);
	HSEL <= 1'b1;
	HTRANS <= HTRANS_NONSEQ;
	HWRITE <= wr;
	HADDR <= {20'h00000, a};
	hrdy();
	HSEL <= 1'b0;
	HTRANS <= 2'h0;
	HWDATA <= d;
	hrdy();
endtask
function logic [8:0] emap(input logic [31:0] g);
	return {g[PHY_BIT], g[MAC_BIT], g[6:0]};
endfunction
always @(posedge I_CLK) begin
	if (ph && O_HREADYOUT) begin
		chk(O_HRESP, exp_r.pop_front());
		if (ph_rd)
			chk(O_HRDATA, exp_d.pop_front());
	end
	if (O_HREADYOUT) begin
		ph = HSEL && HTRANS[1];
		ph_rd = HSEL && HTRANS[1] && !HWRITE;
	end
	if (req_q)
		chk(O_UNIT_FAULT, exp_f.pop_front());
	req_q = I_UNIT_REQ;
end
initial begin
	logic [31:0] r, rg, sg, e;
	int m, a, s;
	waitc(10);
	I_NRST <= 1'b1;
	waitc(1);
	bus(1'b0, SLEEP_GATE_OFS, 32'h0, GATE_RESET);
	chk(O_UNIT_CLK_EN, 32'h0);
	$display("test 1 done");
	r = ($random(seed) & GATE_MASK) | (GATE_RESET & ~GATE_MASK);
	sg = r & GATE_MASK;
	rg = 32'h00000001;
	bus(1'b1, SLEEP_GATE_OFS, r);
	bus(1'b0, SLEEP_GATE_OFS, 32'h0, sg);
	bus(1'b1, RUN_GATE_OFS, rg | 32'hA0000080);
	for (a = 0; a < 2; a++) begin
		bus(1'b1, RUN_CFG_OFS, a ? CFG_MASK : 32'h0);
		for (m = 0; m < 4; m++) begin
			I_POWER_MODE <= m[1:0];
			waitc(8);
			e = (a && m == 1) ? sg : (a && m == 2) ? GATE_RESET : rg;
			chk(O_UNIT_CLK_EN, emap(e));
		end
	end
	bus(1'b0, MODE_STAT_OFS, 32'h0, 32'h3);
	$display("test 2 done");
	for (s = 0; s < 10; s++) begin
		go <= 1'b1;
		sel <= s[3:0];
		exp_f.push_back({31'h0, s > 0 && s < 9});
		waitc(1);
	end
	go <= 1'b0;
	waitc(4);
	chk(O_IRQ, 32'h0);
	bus(1'b1, INT_MASK_OFS, 32'h1);
	waitc(2);
	chk(O_IRQ, 32'h1);
	bus(1'b0, INT_STAT_OFS, 32'h0, 32'h3);
	bus(1'b1, INT_STAT_OFS, 32'h3);
	waitc(2);
	chk(O_IRQ, 32'h0);
	$display("test 3 done");
	bus(1'b1, 12'h200, 32'h0, 32'h0, 32'h1);
	bus(1'b0, RUN_GATE_OFS, 32'h0, rg);
	waitc(3);
	$display("test 4 done");
	conclude();
end
endmodule
